// ---- hdl/gpx_pkg.sv ----
/*
 gpx_pkg: constants, types and register map of the eight-pin port.
 assumes one APB3 slave on pclk, 32-bit data, byte addresses.
*/
package gpx_pkg;
	localparam int NPIN = 8;
	localparam int AW = 8;
	// register byte offsets
	localparam logic [AW-1:0] A_DIR = 8'h00;
	localparam logic [AW-1:0] A_SENSE = 8'h04;
	localparam logic [AW-1:0] A_PAD = 8'h08;
	localparam logic [AW-1:0] A_PSEL = 8'h0c;
	localparam logic [AW-1:0] A_INFO = 8'h10;
	localparam logic [AW-1:0] A_DOUT = 8'h14;
	localparam logic [AW-1:0] A_DIN = 8'h18;
	localparam logic [AW-1:0] A_ISTAT = 8'h1c;
	localparam logic [AW-1:0] A_IMASK = 8'h20;
	// field positions
	localparam int F_MASK = 0;
	localparam int F_VAL = 8;
	localparam int F_TYPE = 12;
	localparam int I_DIR = 0;
	localparam int I_SNS = 4;
	localparam int I_STR = 8;
	localparam int I_TYPE = 12;
	localparam int I_PADOK = 16;

	typedef enum logic [1:0] {
		DIR_IN = 2'h0,
		DIR_OUT = 2'h1,
		DIR_HW = 2'h2
	} gpx_dir_t;
	typedef enum logic [2:0] {
		SNS_FALL = 3'h0,
		SNS_RISE = 3'h1,
		SNS_BOTH = 3'h2,
		SNS_LOW = 3'h3,
		SNS_HIGH = 3'h4
	} gpx_sense_t;
	typedef enum logic [1:0] {
		STR_2MA = 2'h0,
		STR_4MA = 2'h1,
		STR_8MA = 2'h2,
		STR_8MA_SC = 2'h3
	} gpx_str_t;
	typedef enum logic [2:0] {
		PT_STD = 3'h0,
		PT_STD_WPU = 3'h1,
		PT_STD_WPD = 3'h2,
		PT_OD = 3'h3,
		PT_OD_WPU = 3'h4,
		PT_OD_WPD = 3'h5,
		PT_ANALOG = 3'h6
	} gpx_ptype_t;

	typedef struct packed {
		gpx_dir_t dir;
		gpx_sense_t sense;
		gpx_str_t strength;
		gpx_ptype_t ptype;
		logic pad_ok;
	} gpx_cfg_t;

	localparam gpx_cfg_t CFG_RST = '{dir: DIR_IN, sense: SNS_FALL, strength: STR_2MA,
		ptype: PT_STD, pad_ok: 1'b0};
	localparam logic [NPIN-1:0] BYTE_RST = 8'h00;
endpackage : gpx_pkg

// ---- hdl/gpx_pin_cfg.sv ----
/*
 gpx_pin_cfg: configuration storage of one pin.
 assumes the caller validated the written codes and the mask bit.
*/
`timescale 1ns/10ps
module gpx_pin_cfg (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, low
	input wire logic sel, // pin chosen by mask
	input wire logic wr_dir, // direction write
	input wire logic wr_sense, // sense write
	input wire logic wr_pad, // pad write
	input gpx_pkg::gpx_cfg_t wval, // values written
	output gpx_pkg::gpx_cfg_t cfg // held settings
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= gpx_pkg::CFG_RST;
		end else if (sel) begin
			if (wr_dir)
				cfg.dir <= wval.dir;
			if (wr_sense)
				cfg.sense <= wval.sense;
			if (wr_pad) begin
				cfg.strength <= wval.strength;
				cfg.ptype <= wval.ptype;
				cfg.pad_ok <= 1'b1;
			end
		end
	end
endmodule : gpx_pin_cfg

// ---- hdl/gpx_irq_detect.sv ----
/*
 gpx_irq_detect: interrupt sense detector of one pin.
 assumes din is already gated by the pad and synchronous to pclk.
*/
`timescale 1ns/10ps
module gpx_irq_detect (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, low
	input gpx_pkg::gpx_sense_t sense, // sense type
	input wire logic din, // gated pin level
	output logic hit // event this cycle
);
	logic prev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prev <= 1'b0;
		else
			prev <= din;
	end

	always_comb begin
		case (sense)
			gpx_pkg::SNS_FALL: hit = prev & ~din;
			gpx_pkg::SNS_RISE: hit = ~prev & din;
			gpx_pkg::SNS_BOTH: hit = prev ^ din;
			gpx_pkg::SNS_LOW: hit = ~din;
			gpx_pkg::SNS_HIGH: hit = din;
			default: hit = 1'b0;
		endcase
	end
endmodule : gpx_irq_detect

// ---- hdl/gpx_port.sv ----
/*
 gpx_port: eight-pin general-purpose port, APB3 slave with zero wait.
 assumes pin inputs and peripheral signals are synchronous to pclk.
*/
`timescale 1ns/10ps
module gpx_port #(
	parameter int NPIN = gpx_pkg::NPIN
) (
	input wire logic pclk, // clock, 100 MHz
	input wire logic presetn, // async reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb write
	input wire logic [gpx_pkg::AW-1:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic [NPIN-1:0] pin_in, // pad input levels
	output logic [NPIN-1:0] pin_out, // pad output level
	output logic [NPIN-1:0] pin_oe, // pad output enable
	output logic [NPIN-1:0] pin_pu, // weak pull-up on
	output logic [NPIN-1:0] pin_pd, // weak pull-down on
	output logic [NPIN-1:0][1:0] drive_strength_out, // per-pin strength
	output logic [NPIN-1:0][2:0] pad_type_out, // per-pin pad type
	input wire logic [NPIN-1:0] hw_out, // peripheral output
	input wire logic [NPIN-1:0] hw_oe, // peripheral output enable
	output logic [NPIN-1:0] hw_in, // input to peripheral
	output logic irq // level interrupt
);
	////////////////////////////////////////////////////////////////
	// bus decode
	logic access;
	logic wr;
	logic hit_addr;
	logic [NPIN-1:0] pin_select_mask;
	logic wr_dir;
	logic wr_sense;
	logic wr_pad;
	logic dir_ok;
	logic sense_ok;
	logic pad_ok_val;
	gpx_pkg::gpx_cfg_t wval;
	gpx_pkg::gpx_cfg_t cfg [NPIN];
	logic [2:0] pin_index;
	logic [NPIN-1:0] data_out;
	logic [NPIN-1:0] in_gated;
	logic [NPIN-1:0] ev;
	logic [NPIN-1:0] istat;
	logic [NPIN-1:0] imask;
	logic [NPIN-1:0] iclr;
	logic [NPIN-1:0] next_istat;
	logic [31:0] rmux;

	assign access = psel & penable;
	assign wr = access & pwrite;
	assign pready = 1'b1;
	assign pin_select_mask = pwdata[gpx_pkg::F_MASK +: NPIN];
	assign dir_ok = pwdata[gpx_pkg::F_VAL +: 2] <= gpx_pkg::DIR_HW;
	assign sense_ok = pwdata[gpx_pkg::F_VAL +: 3] <= gpx_pkg::SNS_HIGH;
	assign pad_ok_val = pwdata[gpx_pkg::F_TYPE +: 3] <= gpx_pkg::PT_ANALOG;
	assign wr_dir = wr && paddr == gpx_pkg::A_DIR && dir_ok;
	assign wr_sense = wr && paddr == gpx_pkg::A_SENSE && sense_ok;
	assign wr_pad = wr && paddr == gpx_pkg::A_PAD && pad_ok_val;

	always_comb begin
		wval = gpx_pkg::CFG_RST;
		wval.dir = gpx_pkg::gpx_dir_t'(pwdata[gpx_pkg::F_VAL +: 2]);
		wval.sense = gpx_pkg::gpx_sense_t'(pwdata[gpx_pkg::F_VAL +: 3]);
		wval.strength = gpx_pkg::gpx_str_t'(pwdata[gpx_pkg::F_VAL +: 2]);
		wval.ptype = gpx_pkg::gpx_ptype_t'(pwdata[gpx_pkg::F_TYPE +: 3]);
	end

	always_comb begin
		case (paddr)
			gpx_pkg::A_DIR, gpx_pkg::A_SENSE, gpx_pkg::A_PAD, gpx_pkg::A_PSEL,
			gpx_pkg::A_INFO, gpx_pkg::A_DOUT, gpx_pkg::A_DIN, gpx_pkg::A_ISTAT,
			gpx_pkg::A_IMASK: hit_addr = 1'b1;
			default: hit_addr = 1'b0;
		endcase
	end
	assign pslverr = access & ~hit_addr;

	////////////////////////////////////////////////////////////////
	// per-pin storage and detectors
	for (genvar i = 0; i < NPIN; i++) begin : g_pin
		gpx_pin_cfg u_cfg (
			.pclk(pclk),
			.presetn(presetn),
			.sel(pin_select_mask[i]),
			.wr_dir(wr_dir),
			.wr_sense(wr_sense),
			.wr_pad(wr_pad),
			.wval(wval),
			.cfg(cfg[i])
		);
		gpx_irq_detect u_det (
			.pclk(pclk),
			.presetn(presetn),
			.sense(cfg[i].sense),
			.din(in_gated[i]),
			.hit(ev[i])
		);
		// pad path only after pad config, analog has no digital path
		assign in_gated[i] = cfg[i].pad_ok && cfg[i].ptype != gpx_pkg::PT_ANALOG
			&& pin_in[i];
	end

	////////////////////////////////////////////////////////////////
	// plain registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pin_index <= 3'h0;
		else if (wr && paddr == gpx_pkg::A_PSEL)
			pin_index <= pwdata[2:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			data_out <= gpx_pkg::BYTE_RST;
		else if (wr && paddr == gpx_pkg::A_DOUT)
			data_out <= pwdata[NPIN-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			imask <= gpx_pkg::BYTE_RST;
		else if (wr && paddr == gpx_pkg::A_IMASK)
			imask <= pwdata[NPIN-1:0];
	end

	////////////////////////////////////////////////////////////////
	// interrupt status, set wins over write-one clear
	assign iclr = (wr && paddr == gpx_pkg::A_ISTAT) ? pwdata[NPIN-1:0] : '0;
	assign next_istat = (istat & ~iclr) | ev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			istat <= gpx_pkg::BYTE_RST;
		else
			istat <= next_istat;
	end
	assign irq = |(istat & imask);

	////////////////////////////////////////////////////////////////
	// pad drive, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out <= '0;
			pin_oe <= '0;
			pin_pu <= '0;
			pin_pd <= '0;
			drive_strength_out <= '0;
			pad_type_out <= '0;
			hw_in <= '0;
		end else begin
			for (int i = 0; i < NPIN; i++) begin
				logic drv;
				logic drv_en;
				logic od;
				drv = cfg[i].dir == gpx_pkg::DIR_HW ? hw_out[i] : data_out[i];
				drv_en = cfg[i].pad_ok && cfg[i].ptype != gpx_pkg::PT_ANALOG &&
					(cfg[i].dir == gpx_pkg::DIR_OUT ||
					(cfg[i].dir == gpx_pkg::DIR_HW && hw_oe[i]));
				od = cfg[i].ptype inside {gpx_pkg::PT_OD, gpx_pkg::PT_OD_WPU,
					gpx_pkg::PT_OD_WPD};
				pin_out[i] <= od ? 1'b0 : drv;
				pin_oe[i] <= od ? (drv_en & ~drv) : drv_en;
				pin_pu[i] <= cfg[i].pad_ok && cfg[i].ptype inside {gpx_pkg::PT_STD_WPU,
					gpx_pkg::PT_OD_WPU};
				pin_pd[i] <= cfg[i].pad_ok && cfg[i].ptype inside {gpx_pkg::PT_STD_WPD,
					gpx_pkg::PT_OD_WPD};
				drive_strength_out[i] <= cfg[i].strength;
				pad_type_out[i] <= cfg[i].ptype;
				hw_in[i] <= cfg[i].dir == gpx_pkg::DIR_HW && in_gated[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// read data, captured in the setup cycle
	always_comb begin
		rmux = '0;
		case (paddr)
			gpx_pkg::A_PSEL: rmux[2:0] = pin_index;
			gpx_pkg::A_INFO: begin
				rmux[gpx_pkg::I_DIR +: 2] = cfg[pin_index].dir;
				rmux[gpx_pkg::I_SNS +: 3] = cfg[pin_index].sense;
				rmux[gpx_pkg::I_STR +: 2] = cfg[pin_index].strength;
				rmux[gpx_pkg::I_TYPE +: 3] = cfg[pin_index].ptype;
				rmux[gpx_pkg::I_PADOK] = cfg[pin_index].pad_ok;
			end
			gpx_pkg::A_DOUT: rmux[NPIN-1:0] = data_out;
			gpx_pkg::A_DIN: rmux[NPIN-1:0] = in_gated;
			gpx_pkg::A_ISTAT: rmux[NPIN-1:0] = istat;
			gpx_pkg::A_IMASK: rmux[NPIN-1:0] = imask;
			default: rmux = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= '0;
		else if (psel && !penable)
			prdata <= rmux;
	end

	////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic rd_info;
	assign rd_info = psel && !penable && !pwrite && paddr == gpx_pkg::A_INFO;

	property p_mask_only;
		wr_dir && !pwdata[0] |=> $stable(cfg[0].dir);
	endproperty
	a_mask_only: assert property (p_mask_only) else $error("unmasked pin changed");

	property p_dir_hw;
		wr_dir && pwdata[0] && pwdata[9:8] == 2'h2 |=> cfg[0].dir == gpx_pkg::DIR_HW;
	endproperty
	a_dir_hw: assert property (p_dir_hw) else $error("hardware mode not taken");

	property p_dir_read;
		rd_info |=> prdata[1:0] == $past(cfg[pin_index].dir);
	endproperty
	a_dir_read: assert property (p_dir_read) else $error("direction readback wrong");

	property p_low_level;
		cfg[0].sense == gpx_pkg::SNS_LOW && !in_gated[0] |=> istat[0];
	endproperty
	a_low_level: assert property (p_low_level) else $error("low level missed");

	property p_sense_read;
		rd_info |=> prdata[6:4] == $past(cfg[pin_index].sense);
	endproperty
	a_sense_read: assert property (p_sense_read) else $error("sense readback wrong");

	property p_sense_all;
		wr_sense && pwdata[0] && pwdata[7] |=> cfg[0].sense == cfg[7].sense
			&& cfg[0].sense == $past(pwdata[10:8]);
	endproperty
	a_sense_all: assert property (p_sense_all) else $error("sense not applied together");

	property p_no_pad;
		!cfg[0].pad_ok |-> !in_gated[0] ##1 !pin_oe[0];
	endproperty
	a_no_pad: assert property (p_no_pad) else $error("pad passed unconfigured");

	property p_pad_read;
		rd_info |=> prdata[14:12] == $past(cfg[pin_index].ptype)
			&& prdata[9:8] == $past(cfg[pin_index].strength);
	endproperty
	a_pad_read: assert property (p_pad_read) else $error("pad readback wrong");

	property p_reset_dir;
		$rose(presetn) |-> cfg[3].dir == gpx_pkg::DIR_IN && !hw_in[3];
	endproperty
	a_reset_dir: assert property (p_reset_dir) else $error("pin not input after reset");

	property p_reset_pull;
		$rose(presetn) |-> pin_pu == '0 && pin_pd == '0;
	endproperty
	a_reset_pull: assert property (p_reset_pull) else $error("pull on after reset");

	property p_hold;
		!wr |=> $stable(cfg[5]);
	endproperty
	a_hold: assert property (p_hold) else $error("setting lost without write");

	property p_set_wins;
		ev[1] |=> istat[1];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost");

	c_irq: cover property (imask[0] && ev[0] ##1 irq);
	c_od: cover property (wr_pad && pwdata[0] && pwdata[14:12] == 3'h3);
	c_info: cover property (rd_info && pin_index == 3'h7);
	c_err: cover property (pslverr);
endmodule : gpx_port

// ---- bench/gpx_pad_model.sv ----
/*
 gpx_pad_model: outside world of the port pins, a source plus pad pulls.
 assumes pin drive from gpx_port on pclk; released lines float.
*/
`timescale 1ns/10ps
module gpx_pad_model (
	input wire logic pclk, // clock
	input wire logic [7:0] pin_out, // port drive level
	input wire logic [7:0] pin_oe, // port drives
	input wire logic [7:0] pin_pu, // weak pull-up
	input wire logic [7:0] pin_pd, // weak pull-down
	input wire logic [7:0] ext_val, // source level
	input wire logic [7:0] ext_en, // source drives
	output logic [7:0] pin_in // wire level
);
	logic [7:0] drift = 8'h3c;

	////////////////////////////////////////
	// an undriven, unpulled wire wanders every cycle
	always @(posedge pclk) drift <= ~drift;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i]) pin_in[i] = pin_out[i];
			else if (ext_en[i]) pin_in[i] = ext_val[i];
			else if (pin_pu[i] || pin_pd[i]) pin_in[i] = pin_pu[i];
			else pin_in[i] = drift[i];
		end
	end
endmodule : gpx_pad_model

// ---- bench/gpx_port_tb.sv ----
/*
 gpx_port_tb: self-checking bench of the eight-pin port over apb.
 assumes gpx_pkg, gpx_port and gpx_pad_model are compiled first.
*/
`timescale 1ns/10ps
module gpx_port_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, perr;
	logic [7:0] paddr, pin_in, pin_out, pin_oe, pin_pu, pin_pd, hw_out, hw_oe, hw_in;
	logic [7:0] ext_val, ext_en, m;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0][1:0] dso;
	logic [7:0][2:0] pto;
	logic [1:0] e_dir[8], e_str[8];
	logic [2:0] e_sns[8], e_typ[8], v, t;
	logic e_ok[8];
	int err_total = 0, cmp_count = 0, cyc = 0, op;
	integer seed = 98;

	gpx_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pu(pin_pu), .pin_pd(pin_pd), .drive_strength_out(dso), .pad_type_out(pto),
		.hw_out(hw_out), .hw_oe(hw_oe), .hw_in(hw_in), .irq(irq));
	gpx_pad_model pad (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu),
		.pin_pd(pin_pd), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	////////////////////////////////////////
	function automatic logic [31:0] info(int p);
		return {15'h0, e_ok[p], 1'b0, e_typ[p], 2'h0, e_str[p], 1'b0, e_sns[p], 2'h0, e_dir[p]};
	endfunction : info

	task automatic finish_test;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic cfg(input int o, input logic [7:0] mk, input logic [2:0] vv,
		input logic [2:0] tt);
		for (int i = 0; i < 8; i++) begin
			if (mk[i] && o == 0 && vv < 3) e_dir[i] = vv[1:0];
			if (mk[i] && o == 1 && vv < 5) e_sns[i] = vv;
			if (mk[i] && o == 2 && tt < 7) e_str[i] = vv[1:0];
			if (mk[i] && o == 2 && tt < 7) e_typ[i] = tt;
			if (mk[i] && o == 2 && tt < 7) e_ok[i] = 1'b1;
		end
		apb(1'b1, 8'(4 * o), 32'(mk) | (32'(vv) << gpx_pkg::F_VAL)
			| (32'(tt) << gpx_pkg::F_TYPE));
	endtask : cfg

	task automatic chk_all;
		for (int p = 0; p < 8; p++) begin
			apb(1'b1, gpx_pkg::A_PSEL, 32'(p));
			apb(1'b0, gpx_pkg::A_INFO, 32'h0);
			chk(rd, info(p));
			chk(32'({dso[p], pto[p]}), 32'({e_str[p], e_typ[p]}));
		end
	endtask : chk_all

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			$display("BAD t=%0t got %h exp %h cycle limit", $time, cyc, 0);
			finish_test;
		end
	end

	////////////////////////////////////////
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, hw_out, hw_oe} = '0;
		ext_val = 8'h5a;
		ext_en = 8'hff;
		for (int i = 0; i < 8; i++) begin
			{e_dir[i], e_str[i], e_sns[i], e_typ[i], e_ok[i]} = '0;
		end
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk_all;
		chk(32'({pin_pu, pin_pd, pin_oe}), 32'h0);
		apb(1'b0, gpx_pkg::A_DIN, 32'h0);
		chk(rd, 32'h0);
		$display("reset test done");
		for (int c = 0; c < 5; c++) cfg(1, 8'h01 << c, 3'(c), 3'h0);
		for (int c = 0; c < 3; c++) cfg(0, 8'h20 << c, 3'(c), 3'h0);
		cfg(0, 8'h00, 3'h1, 3'h0);
		cfg(0, 8'hff, 3'h3, 3'h0);
		repeat (30) begin
			op = {$random(seed)} % 3;
			m = 8'($random(seed));
			v = 3'($random(seed));
			t = 3'($random(seed));
			if (op != 1) v[2] = 1'b0;
			if (op != 2) t = 3'h0;
			cfg(op, m, v, t);
		end
		chk_all;
		$display("config test done");
		cfg(0, 8'hff, 3'h0, 3'h0);
		cfg(2, 8'h7f, 3'h0, 3'h0);
		cfg(2, 8'h80, 3'h0, 3'h1);
		ext_en <= 8'h7f;
		// source stays steady across the sense change
		cfg(1, 8'hff, 3'h1, 3'h0);
		repeat (3) @(posedge pclk);
		apb(1'b0, gpx_pkg::A_DIN, 32'h0);
		chk(rd, 32'hda);
		chk(32'(pin_pu), 32'h80);
		apb(1'b1, gpx_pkg::A_IMASK, 32'h1);
		apb(1'b1, gpx_pkg::A_ISTAT, 32'hff);
		chk(32'(irq), 32'h0);
		ext_val <= 8'h5b;
		repeat (4) @(posedge pclk);
		apb(1'b0, gpx_pkg::A_ISTAT, 32'h0);
		chk(rd, 32'h1);
		chk(32'(irq), 32'h1);
		apb(1'b1, gpx_pkg::A_IMASK, 32'h0);
		chk(32'(irq), 32'h0);
		apb(1'b1, gpx_pkg::A_ISTAT, 32'h1);
		apb(1'b0, gpx_pkg::A_ISTAT, 32'h0);
		chk(rd, 32'h0);
		$display("pad and irq test done");
		hw_out <= 8'($random(seed));
		hw_oe <= 8'h30;
		cfg(0, 8'h0f, 3'h1, 3'h0);
		cfg(0, 8'h30, 3'h2, 3'h0);
		apb(1'b1, gpx_pkg::A_DOUT, 32'ha5);
		repeat (3) @(posedge pclk);
		chk(32'({pin_oe, pin_out & 8'h3f}), 32'({8'h3f, 2'h0, hw_out[5:4], 4'h5}));
		chk(32'(hw_in), 32'({2'h0, hw_out[5:4], 4'h0}));
		// open drain on pins 0 and 1, analog on 2 and 6, pull-down on 7
		cfg(2, 8'h03, 3'h1, 3'h3);
		cfg(2, 8'h44, 3'h2, 3'h6);
		cfg(2, 8'h80, 3'h3, 3'h5);
		repeat (3) @(posedge pclk);
		chk(32'({pin_oe, pin_pu, pin_pd}), 32'h003a0080);
		apb(1'b0, gpx_pkg::A_DIN, 32'h0);
		chk(rd, 32'({2'h0, hw_out[5:4], 4'h1}));
		chk_all;
		apb(1'b0, 8'h40, 32'h0);
		chk(32'(perr), 32'h1);
		chk(rd, 32'h0);
		$display("output test done");
		finish_test;
	end
endmodule : gpx_port_tb
